// >>> src/rcm_top.sv
// top of the rtc oscillator cap stepping and clock monitor
`timescale 1ns/1ns
`include "rcm_consts.svh"
module rcm_top #(
  parameter int MISS_CYCLES = `RCM_MISS_CYCLES,
  parameter int BLANK_CYCLES = `RCM_BLANK_CYCLES,
  parameter int STEP_OSC_CYCLES = `RCM_STEP_OSC_CYCLES
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire rcm_pkg::rcm_ctrl_t ctrl,
  input wire logic [3:0] target_cap,
  input wire logic osc_fail_clear,
  input wire logic osc_in,
  input wire logic amp_det_in,
  output logic [3:0] load_cap_code,
  output logic cap_target_reached,
  output logic osc_power_out,
  output logic crystal_mode_out,
  output logic bias_double_out,
  output logic agc_out,
  output logic osc_fail_flag,
  output logic osc_fail_detector_out,
  output logic crystal_valid,
  output logic crystal_valid_blank
);
  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic osc_s1_reg, osc_s2_reg, amp_s1_reg, amp_s2_reg;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      amp_s1_reg <= 1'b0;
      amp_s2_reg <= 1'b0;
    end else begin
      osc_s1_reg <= osc_in;
      osc_s2_reg <= osc_s1_reg;
      amp_s1_reg <= amp_det_in;
      amp_s2_reg <= amp_s1_reg;
    end
  end
  // ------------------------------------------------------------
  // oscillator edge counting for step pacing
  // ------------------------------------------------------------
  logic osc_d_reg, osc_d_next;
  logic osc_rise;
  assign osc_d_next = osc_s2_reg;
  assign osc_rise = osc_s2_reg & ~osc_d_reg;
  // ------------------------------------------------------------
  // capacitance stepping
  // ------------------------------------------------------------
  rcm_pkg::rcm_step_state_t st_reg, st_next;
  logic [3:0] code_reg, code_next;
  logic [3:0] tgt_reg, tgt_next;
  logic [7:0] pace_reg, pace_next;
  logic rdy_reg, rdy_next;
  logic en_d_reg, en_d_next;
  logic restart;
  assign en_d_next = ctrl.osc_power_en;
  // a new target or a fresh power-up restarts the ramp
  assign restart = (target_cap != tgt_reg) | (ctrl.osc_power_en & ~en_d_reg);
  always_comb begin
    st_next = st_reg;
    code_next = code_reg;
    pace_next = pace_reg;
    rdy_next = rdy_reg;
    tgt_next = target_cap; // [RQ1]
    if (!ctrl.osc_power_en) begin
      st_next = rcm_pkg::RCM_IDLE;
      code_next = `RCM_CAP_MIN;
      pace_next = 8'h00;
      rdy_next = 1'b0;
    end else if (restart) begin
      rdy_next = 1'b0; // [RQ18]
      pace_next = 8'h00;
      if (ctrl.auto_step_en) begin
        st_next = rcm_pkg::RCM_STEP;
        code_next = (ctrl.osc_power_en & ~en_d_reg) ? `RCM_CAP_MIN : code_reg; // [RQ2]
      end else begin
        st_next = rcm_pkg::RCM_DONE;
        code_next = target_cap;
      end
    end else begin
      case (st_reg)
        rcm_pkg::RCM_IDLE: begin
          st_next = ctrl.auto_step_en ? rcm_pkg::RCM_STEP : rcm_pkg::RCM_DONE;
          code_next = ctrl.auto_step_en ? `RCM_CAP_MIN : tgt_reg;
        end
        rcm_pkg::RCM_STEP: begin
          if (code_reg == tgt_reg) begin
            st_next = rcm_pkg::RCM_DONE;
            rdy_next = 1'b1; // [RQ3]
          end else if (osc_rise) begin
            if (pace_reg == 8'(STEP_OSC_CYCLES - 1)) begin
              pace_next = 8'h00;
              // move one step toward the target, never past it
              code_next = (code_reg < tgt_reg) ? code_reg + 4'h1 : code_reg - 4'h1; // [RQ17]
            end else begin
              pace_next = pace_reg + 8'h01;
            end
          end
        end
        rcm_pkg::RCM_DONE: begin
          code_next = tgt_reg;
          rdy_next = 1'b1; // [RQ3]
        end
        default: begin
          st_next = rcm_pkg::RCM_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= rcm_pkg::RCM_IDLE;
      code_reg <= `RCM_CAP_MIN;
      tgt_reg <= `RCM_CAP_MIN;
      pace_reg <= 8'h00;
      rdy_reg <= 1'b0;
      en_d_reg <= 1'b0;
      osc_d_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      code_reg <= code_next;
      tgt_reg <= tgt_next;
      pace_reg <= pace_next;
      rdy_reg <= rdy_next;
      en_d_reg <= en_d_next;
      osc_d_reg <= osc_d_next;
    end
  end
  // ------------------------------------------------------------
  // missing clock detector and sticky fail flag
  // ------------------------------------------------------------
  logic miss_timeout;
  logic fail_reg, fail_next;
  logic evt_reg, evt_next;
  rcm_miss_det #(
    .MISS_CYCLES(MISS_CYCLES)
  ) rcm_miss_det_i (
    .clock(clock),
    .arst_n(arst_n),
    .armed(ctrl.missing_clk_det_en), // [RQ6]
    .osc_sync(osc_s2_reg),
    .timeout(miss_timeout)
  );
  always_comb begin
    // a timeout in the clearing cycle wins over the clear
    fail_next = miss_timeout | (fail_reg & ~osc_fail_clear); // [RQ14]
    evt_next = miss_timeout; // [RQ8]
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fail_reg <= 1'b0;
      evt_reg <= 1'b0;
    end else begin
      fail_reg <= fail_next;
      evt_reg <= evt_next;
    end
  end
  // ------------------------------------------------------------
  // crystal valid with blanking
  // ------------------------------------------------------------
  logic [16:0] blank_reg, blank_next;
  logic blanking_reg, blanking_next;
  logic vld_reg, vld_next;
  always_comb begin
    blank_next = blank_reg;
    if (!ctrl.osc_power_en || !en_d_reg) begin
      blank_next = 17'h00000; // [RQ15]
    end else if (blank_reg < 17'(BLANK_CYCLES)) begin
      blank_next = blank_reg + 17'h00001;
    end
    blanking_next = (blank_next < 17'(BLANK_CYCLES)); // [RQ11]
    vld_next = amp_s2_reg & ctrl.bias_double_en & ctrl.osc_power_en; // [RQ10] [RQ12]
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      blank_reg <= 17'h00000;
      blanking_reg <= 1'b1;
      vld_reg <= 1'b0;
    end else begin
      blank_reg <= blank_next;
      blanking_reg <= blanking_next;
      vld_reg <= vld_next;
    end
  end
  // ------------------------------------------------------------
  // analog control outputs
  // ------------------------------------------------------------
  logic pwr_reg, mode_reg, bias_reg, agc_reg;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pwr_reg <= 1'b0;
      mode_reg <= 1'b0;
      bias_reg <= 1'b0;
      agc_reg <= 1'b0;
    end else begin
      pwr_reg <= ctrl.osc_power_en; // [RQ15]
      mode_reg <= ctrl.osc_mode_sel; // [RQ16]
      bias_reg <= ctrl.bias_double_en; // [RQ5]
      // gain control only passes in crystal mode, as a guard for self-oscillate
      agc_reg <= ctrl.agc_en & ctrl.osc_mode_sel; // [RQ4]
    end
  end
  assign load_cap_code = code_reg;
  assign cap_target_reached = rdy_reg;
  assign osc_power_out = pwr_reg;
  assign crystal_mode_out = mode_reg;
  assign bias_double_out = bias_reg;
  assign agc_out = agc_reg;
  assign osc_fail_flag = fail_reg;
  assign osc_fail_detector_out = evt_reg;
  assign crystal_valid = vld_reg;
  assign crystal_valid_blank = blanking_reg;
endmodule

// >>> src/rcm_consts.svh
// constants for the rtc oscillator cap stepping and clock monitor
// Operation
// RQ1: 4-bit load code, 0000 smallest, 1111 largest
// RQ2: stepping starts smallest, rises to target; a new target instead steps up or down from the current code
// RQ3: set target-reached flag when code equals target
// RQ4: software keeps gain control off in self-oscillate
// RQ5: bias double follows its control bit
// RQ6: detector armed only while enable bit set
// RQ7: fail flag when clock static over 100us
// RQ8: detector timeout offered as event output
// RQ9: software disables detector before oscillator changes
// RQ10: crystal-valid status shows amplitude detector output
// RQ11: crystal-valid ignored for 2ms after enable
// RQ12: crystal-valid forced low without bias double
// RQ13: software uses fail flag for failure detection
// RQ14: fail flag sticky until software clears it
// RQ15: enable bit powers oscillator, starts blanking
// RQ16: mode bit one selects crystal operation
// RQ17: code steps one per fixed oscillator cycles
// RQ18: new target or restart clears reached flag
`ifndef RCM_CONSTS_SVH
`define RCM_CONSTS_SVH
`define RCM_CLK_MHZ 25
`define RCM_MISS_TIME_US 100
`define RCM_MISS_CYCLES (`RCM_MISS_TIME_US * `RCM_CLK_MHZ)
`define RCM_BLANK_TIME_US 2000
`define RCM_BLANK_CYCLES (`RCM_BLANK_TIME_US * `RCM_CLK_MHZ)
`define RCM_STEP_OSC_CYCLES 16
`define RCM_CAP_MIN 4'h0
`define RCM_CAP_MAX 4'hf
`endif

// >>> src/rcm_pkg.sv
// types for the rtc oscillator cap stepping and clock monitor
package rcm_pkg;
  typedef enum logic [1:0] {
    RCM_IDLE = 2'b00,
    RCM_STEP = 2'b01,
    RCM_DONE = 2'b10
  } rcm_step_state_t;
  typedef struct packed {
    logic osc_power_en;
    logic osc_mode_sel;
    logic bias_double_en;
    logic agc_en;
    logic auto_step_en;
    logic missing_clk_det_en;
  } rcm_ctrl_t;
endpackage

// >>> src/rcm_miss_det.sv
// missing clock detector: static level timeout on synchronised oscillator
`timescale 1ns/1ns
`include "rcm_consts.svh"
module rcm_miss_det #(
  parameter int MISS_CYCLES = `RCM_MISS_CYCLES
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic armed,
  input wire logic osc_sync,
  output logic timeout
);
  // ------------------------------------------------------------
  // level watch
  // ------------------------------------------------------------
  logic [15:0] cnt_reg, cnt_next;
  logic last_reg, last_next;
  logic timeout_reg, timeout_next;
  always_comb begin
    last_next = osc_sync;
    timeout_next = 1'b0;
    cnt_next = cnt_reg;
    if (!armed || osc_sync != last_reg) begin // [RQ6]
      cnt_next = 16'h0000;
    end else if (cnt_reg < 16'(MISS_CYCLES)) begin
      cnt_next = cnt_reg + 16'h0001;
    end else begin
      // one-shot: fires once, then holds until an edge or disarm
      timeout_next = (cnt_reg == 16'(MISS_CYCLES)); // [RQ7]
      cnt_next = 16'(MISS_CYCLES) + 16'h0001;
    end
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 16'h0000;
      last_reg <= 1'b0;
      timeout_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      last_reg <= last_next;
      timeout_reg <= timeout_next;
    end
  end
  assign timeout = timeout_reg;
endmodule

// >>> testbench/rcm_top_monitor.sv
// assertions on the ports of the rtc oscillator cap monitor
`timescale 1ns/1ns
module rcm_top_monitor (
  input wire logic clock,
  input wire logic arst_n,
  input wire rcm_pkg::rcm_ctrl_t ctrl,
  input wire logic [3:0] target_cap,
  input wire logic osc_fail_clear,
  input wire logic [3:0] load_cap_code,
  input wire logic cap_target_reached,
  input wire logic bias_double_out,
  input wire logic agc_out,
  input wire logic osc_fail_flag,
  input wire logic osc_fail_detector_out,
  input wire logic crystal_valid,
  input wire logic crystal_valid_blank
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // ----------
  // sequences
  // ----------
  sequence power_on_s;
    $rose(ctrl.osc_power_en);
  endsequence
  sequence blank_hold_s;
    ##3 crystal_valid_blank [*8];
  endsequence
  sequence ramp_move_s;
    $past(ctrl.auto_step_en) && ctrl.auto_step_en && $past(ctrl.osc_power_en) && ctrl.osc_power_en
      && load_cap_code != $past(load_cap_code);
  endsequence
  // ----------
  // checks
  // ----------
  bias_follow_a: assert property ($past(arst_n) |-> bias_double_out == $past(ctrl.bias_double_en))
    else $error("bias double copy wrong");
  valid_forced_a: assert property (crystal_valid |-> $past(ctrl.bias_double_en))
    else $error("crystal valid without bias double");
  reached_code_a: assert property (cap_target_reached && $stable(target_cap) |-> load_cap_code == target_cap)
    else $error("reached flag with code off target");
  ramp_step_a: assert property (ramp_move_s |->
    load_cap_code == $past(load_cap_code) + 4'h1 || load_cap_code == $past(load_cap_code) - 4'h1)
    else $error("ramp moved more than one step");
  fail_sticky_a: assert property ($past(osc_fail_flag) && !$past(osc_fail_clear) |-> osc_fail_flag)
    else $error("fail flag dropped without clear");
  fail_set_a: assert property (osc_fail_detector_out |-> osc_fail_flag)
    else $error("timeout did not set fail flag");
  armed_only_a: assert property (osc_fail_detector_out |-> $past(ctrl.missing_clk_det_en, 2))
    else $error("timeout while disarmed");
  event_pulse_a: assert property (osc_fail_detector_out |=> !osc_fail_detector_out)
    else $error("timeout event longer than one cycle");
  blank_start_a: assert property (power_on_s |-> blank_hold_s)
    else $error("blanking not started at power on");
  agc_gate_a: assert property (agc_out |-> $past(ctrl.osc_mode_sel))
    else $error("gain control on in self oscillate");
endmodule
bind rcm_top rcm_top_monitor rcm_top_monitor_i (.*);

// >>> testbench/rcm_top_bench.sv
// self-checking bench for the rtc oscillator cap monitor
`timescale 1ns/1ns
module rcm_top_bench;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  rcm_pkg::rcm_ctrl_t ctrl = '0;
  logic [3:0] target_cap = 4'h0;
  logic osc_fail_clear = 1'b0;
  logic osc_in = 1'b0;
  logic amp_det_in = 1'b0;
  logic osc_run = 1'b0;
  logic [1:0] ph = 2'h0;
  logic [3:0] code;
  logic reached, pwr_o, mode_o, bias_o, agc_o, fail_f, fail_p, cv, blank;
  int n_fail = 0;
  int cmp_count = 0;
  int i, k;
  // short counts keep the run brief; expectations use the same figures
  rcm_top #(.MISS_CYCLES(20), .BLANK_CYCLES(50), .STEP_OSC_CYCLES(2)) rcm_top_i (.clock(clock), .arst_n(arst_n),
    .ctrl(ctrl), .target_cap(target_cap), .osc_fail_clear(osc_fail_clear), .osc_in(osc_in), .amp_det_in(amp_det_in),
    .load_cap_code(code), .cap_target_reached(reached), .osc_power_out(pwr_o), .crystal_mode_out(mode_o),
    .bias_double_out(bias_o), .agc_out(agc_o), .osc_fail_flag(fail_f), .osc_fail_detector_out(fail_p),
    .crystal_valid(cv), .crystal_valid_blank(blank));
  always #20 clock = ~clock;
  always begin
    @(posedge clock);
    #2;
    if (osc_run) begin
      ph = ph + 2'h1;
      osc_in = ph[1];
    end
  end
  // ----------
  // helpers
  // ----------
  task tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  // wide enough for the packed flag-and-code compares
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wait_flag(input int lim, ref logic f);
    k = 0;
    while (f !== 1'b1 && k < lim) begin
      tick(1);
      k++;
    end
  endtask
  function logic [3:0] agc_exp(input rcm_pkg::rcm_ctrl_t c);
    return {3'h0, c.agc_en & c.osc_mode_sel};
  endfunction
  initial begin
    #200000;
    n_fail++;
    tally_and_finish;
  end
  // ----------
  // tests
  // ----------
  initial begin
    void'($urandom(32'h3b846516));
    tick(2);
    chk(blank, 1'b1);
    arst_n = 1'b1;
    chk(code, 4'h0);
    for (i = 0; i < 12; i++) begin
      ctrl = 6'($urandom);
      ctrl.missing_clk_det_en = 1'b0;
      target_cap = 4'($urandom);
      tick(1);
      chk(bias_o, ctrl.bias_double_en);
      chk(pwr_o, ctrl.osc_power_en);
      chk(mode_o, ctrl.osc_mode_sel);
      chk(agc_o, agc_exp(ctrl));
    end
    osc_run = 1'b1;
    for (i = 0; i < 3; i++) begin
      ctrl = '0;
      tick(2);
      chk({reached, code}, 5'h00);
      target_cap = (i == 0) ? 4'hf : (i == 1) ? 4'h0 : 4'h1 + 4'($urandom % 14);
      ctrl.osc_power_en = 1'b1;
      ctrl.auto_step_en = 1'b1;
      tick(2);
      chk(code, 4'h0);
      wait_flag(400, reached);
      chk(reached, 1'b1);
      chk(code, target_cap);
    end
    target_cap = ~target_cap;
    tick(2);
    chk(reached, 1'b0);
    wait_flag(400, reached);
    chk(code, target_cap);
    ctrl.auto_step_en = 1'b0;
    target_cap = 4'($urandom);
    tick(3);
    chk(code, target_cap);
    chk(reached, 1'b1);
    ctrl = '0;
    tick(2);
    ctrl.osc_power_en = 1'b1;
    ctrl.bias_double_en = 1'b1;
    amp_det_in = 1'b1;
    tick(4);
    chk(blank, 1'b1);
    chk(cv, 1'b1);
    tick(60);
    chk(blank, 1'b0);
    ctrl.bias_double_en = 1'b0;
    tick(2);
    chk(cv, 1'b0);
    // a stopped oscillator while disarmed must stay silent
    osc_run = 1'b0;
    tick(60);
    chk(fail_f, 1'b0);
    ctrl.missing_clk_det_en = 1'b1;
    wait_flag(80, fail_p);
    chk(fail_p, 1'b1);
    chk(k >= 20, 1'b1);
    tick(1);
    chk({fail_p, fail_f}, 2'b01);
    tick(10);
    chk(fail_f, 1'b1);
    ctrl.missing_clk_det_en = 1'b0;
    osc_fail_clear = 1'b1;
    tick(1);
    osc_fail_clear = 1'b0;
    osc_run = 1'b1;
    tick(1);
    chk(fail_f, 1'b0);
    ctrl.missing_clk_det_en = 1'b1;
    tick(80);
    chk(fail_f, 1'b0);
    arst_n = 1'b0;
    tick(1);
    chk({blank, reached, code}, 6'h20);
    arst_n = 1'b1;
    tick(2);
    chk({blank, code}, {1'b1, target_cap});
    tally_and_finish;
  end
endmodule
